//--- design/tcr_timer.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module tcr_timer
    import tcr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire tcr_bus_t bus_i,
    input wire tcr_pins_t pins_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic rx_baud_o,
    output logic tx_baud_o,
    output logic clk_out_o
);
    // complete state of the block
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [15:0] rcap;
        logic [15:0] cnt;
        logic [1:0] trg_sync;
        logic trg_prev;
        logic [1:0] cin_sync;
        logic cin_prev;
        logic baud_ph;
        logic [7:0] rdata;
        logic irq;
        logic rx_baud;
        logic tx_baud;
        logic clk_out;
    } tcr_state_t;

    tcr_state_t st_r;
    tcr_state_t st_nxt;

    // decoded controls
    logic baud_mode;
    logic trg_fall;
    logic cin_fall;
    logic step;
    logic count_up;
    logic ovf_up;
    logic ovf_dn;
    logic ovf;
    logic ext_edge;

    // mode decode and event detection
    always_comb begin
        baud_mode = st_r.ctrl[TCR_B_RXCLK] | st_r.ctrl[TCR_B_TXCLK];
        // only the second sync stage and its delayed copy are compared
        trg_fall = st_r.trg_prev & ~st_r.trg_sync[1];
        cin_fall = st_r.cin_prev & ~st_r.cin_sync[1];
        ext_edge = trg_fall & st_r.ctrl[TCR_B_EXEN] & ~baud_mode;
        if (!st_r.ctrl[TCR_B_RUN]) begin
            step = 1'b0;
        end else if (baud_mode) begin
            step = st_r.baud_ph;
        end else if (st_r.ctrl[TCR_B_CT]) begin
            step = cin_fall;
        end else begin
            step = pins_i.tick;
        end
        // direction only in plain 16-bit auto-reload
        if (!baud_mode && !st_r.ctrl[TCR_B_CPRL]
            && st_r.mode[TCR_B_DOWN_COUNT_ENABLE]) begin
            count_up = st_r.trg_sync[1];
        end else begin
            count_up = 1'b1;
        end
        ovf_up = step & count_up & (st_r.cnt == TCR_CNT_MAX);
        ovf_dn = step & ~count_up & (st_r.cnt == st_r.rcap);
        ovf = ovf_up | ovf_dn;
    end

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.trg_sync = {st_r.trg_sync[0], pins_i.trigger_pin};
        st_nxt.trg_prev = st_r.trg_sync[1];
        st_nxt.cin_sync = {st_r.cin_sync[0], pins_i.count_input_pin};
        st_nxt.cin_prev = st_r.cin_sync[1];
        // baud phase toggles only while running in baud mode
        if (baud_mode && st_r.ctrl[TCR_B_RUN]) begin
            st_nxt.baud_ph = ~st_r.baud_ph;
        end else begin
            st_nxt.baud_ph = 1'b0;
        end
        // counting
        if (step) begin
            if (ovf_up && (baud_mode || !st_r.ctrl[TCR_B_CPRL])) begin
                st_nxt.cnt = st_r.rcap;
            end else if (ovf_dn) begin
                st_nxt.cnt = TCR_CNT_MAX; // wrap on down match
            end else if (count_up) begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end else begin
                st_nxt.cnt = st_r.cnt - 16'h0001;
            end
        end
        // trigger edge: capture or reload, edge wins over counting
        if (ext_edge) begin
            if (st_r.ctrl[TCR_B_CPRL]) begin
                st_nxt.rcap = st_r.cnt;
                if (st_r.mode[TCR_B_CRST]) begin
                    st_nxt.cnt = TCR_RST_WORD;
                end
            end else if (!st_r.mode[TCR_B_DOWN_COUNT_ENABLE]) begin
                st_nxt.cnt = st_r.rcap;
            end
        end
        // software writes; hardware sets below take priority
        if (bus_i.wr) begin
            case (bus_i.addr)
                TCR_ADDR_CTRL: st_nxt.ctrl = bus_i.wdata;
                TCR_ADDR_MODE: st_nxt.mode = bus_i.wdata & TCR_MODE_MASK;
                TCR_ADDR_RCL: st_nxt.rcap[7:0] = bus_i.wdata;
                TCR_ADDR_RCH: st_nxt.rcap[15:8] = bus_i.wdata;
                TCR_ADDR_CNTL: st_nxt.cnt[7:0] = bus_i.wdata;
                TCR_ADDR_CNTH: st_nxt.cnt[15:8] = bus_i.wdata;
                default: begin
                    // unmapped write is ignored
                end
            endcase
        end
        // flag sets win over a same-cycle software clear
        if (ovf && !baud_mode) begin
            st_nxt.ctrl[TCR_B_OVF] = 1'b1;
        end
        // external flag: set on edge in capture/reload, set on updown ovf
        if (ext_edge) begin
            st_nxt.ctrl[TCR_B_EXF] = 1'b1;
        end
        if (ovf && !baud_mode && st_r.mode[TCR_B_DOWN_COUNT_ENABLE]
            && !st_r.ctrl[TCR_B_CPRL]) begin
            st_nxt.ctrl[TCR_B_EXF] = 1'b1;
        end
        // interrupt follows the flags held in the register
        st_nxt.irq = st_nxt.ctrl[TCR_B_EXF] | st_nxt.ctrl[TCR_B_OVF];
        // baud ticks for the serial port
        if (st_r.ctrl[TCR_B_RXCLK]) begin
            st_nxt.rx_baud = ovf;
        end else begin
            st_nxt.rx_baud = pins_i.t1_ovf;
        end
        if (st_r.ctrl[TCR_B_TXCLK]) begin
            st_nxt.tx_baud = ovf;
        end else begin
            st_nxt.tx_baud = pins_i.t1_ovf;
        end
        // clock out toggles on each overflow, held low when disabled
        if (!st_r.mode[TCR_B_OE]) begin
            st_nxt.clk_out = 1'b0;
        end else if (ovf) begin
            st_nxt.clk_out = ~st_r.clk_out;
        end
        // read data valid the cycle after the strobe only
        st_nxt.rdata = TCR_RST_BYTE;
        if (bus_i.rd) begin
            case (bus_i.addr)
                TCR_ADDR_CTRL: st_nxt.rdata = st_r.ctrl;
                TCR_ADDR_MODE: st_nxt.rdata = st_r.mode;
                TCR_ADDR_RCL: st_nxt.rdata = st_r.rcap[7:0];
                TCR_ADDR_RCH: st_nxt.rdata = st_r.rcap[15:8];
                TCR_ADDR_CNTL: st_nxt.rdata = st_r.cnt[7:0];
                TCR_ADDR_CNTH: st_nxt.rdata = st_r.cnt[15:8];
                default: st_nxt.rdata = TCR_RST_BYTE;
            endcase
        end
    end

    // state register, synchronous active-low reset
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
            st_r.trg_sync <= 2'h3;
            st_r.trg_prev <= 1'b1;
            st_r.cin_sync <= 2'h3;
            st_r.cin_prev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign irq_o = st_r.irq;
    assign rx_baud_o = st_r.rx_baud;
    assign tx_baud_o = st_r.tx_baud;
    assign clk_out_o = st_r.clk_out;

    // assertions
    property p_ovf_set;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ovf && !baud_mode) |=> st_r.ctrl[TCR_B_OVF];
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set");

    property p_ovf_baud;
        @(posedge clk_i) disable iff (!rst_b_i)
        (baud_mode && !st_r.ctrl[TCR_B_OVF] && !bus_i.wr)
            |=> !st_r.ctrl[TCR_B_OVF];
    endproperty
    a_ovf_baud: assert property (p_ovf_baud)
        else $error("overflow flag set in baud mode");

    property p_ovf_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
        (st_r.ctrl[TCR_B_OVF] && !bus_i.wr) |=> st_r.ctrl[TCR_B_OVF];
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow flag cleared by hardware");

    property p_stop;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!st_r.ctrl[TCR_B_RUN] && !bus_i.wr && !ext_edge)
            |=> st_r.cnt == $past(st_r.cnt);
    endproperty
    a_stop: assert property (p_stop)
        else $error("count moved while stopped");

    property p_capture;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ext_edge && st_r.ctrl[TCR_B_CPRL] && !bus_i.wr)
            |=> st_r.rcap == $past(st_r.cnt);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture missed");

    property p_irq;
        @(posedge clk_i) disable iff (!rst_b_i)
        ext_edge |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    property p_baud_rate;
        @(posedge clk_i) disable iff (!rst_b_i)
        (step && baud_mode && !bus_i.wr) |=> !step;
    endproperty
    a_baud_rate: assert property (p_baud_rate)
        else $error("baud step too fast");

    property p_clkout_off;
        @(posedge clk_i) disable iff (!rst_b_i)
        !st_r.mode[TCR_B_OE] |=> !clk_out_o;
    endproperty
    a_clkout_off: assert property (p_clkout_off)
        else $error("clock out while disabled");

    // software writes in the same cycle are excluded, they may move count
    property p_dn_match;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ovf_dn && !bus_i.wr)
            |=> st_r.ctrl[TCR_B_OVF] && (st_r.cnt == TCR_CNT_MAX);
    endproperty
    a_dn_match: assert property (p_dn_match)
        else $error("down match missed");

    property p_reload;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ovf_up && (baud_mode || !st_r.ctrl[TCR_B_CPRL]) && !bus_i.wr)
            |=> st_r.cnt == $past(st_r.rcap);
    endproperty
    a_reload: assert property (p_reload)
        else $error("no reload after overflow");

    property p_trig_reload;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ext_edge && !st_r.ctrl[TCR_B_CPRL] && !st_r.mode[TCR_B_DOWN_COUNT_ENABLE]
            && !bus_i.wr) |=> st_r.cnt == $past(st_r.rcap);
    endproperty
    a_trig_reload: assert property (p_trig_reload)
        else $error("no reload on trigger edge");

    property p_cap_reset;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ext_edge && st_r.ctrl[TCR_B_CPRL] && st_r.mode[TCR_B_CRST]
            && !bus_i.wr) |=> st_r.cnt == TCR_RST_WORD;
    endproperty
    a_cap_reset: assert property (p_cap_reset)
        else $error("count not cleared after capture");

    property p_ext_flag;
        @(posedge clk_i) disable iff (!rst_b_i)
        ext_edge |=> st_r.ctrl[TCR_B_EXF];
    endproperty
    a_ext_flag: assert property (p_ext_flag)
        else $error("external flag not set");

    property p_trig_off;
        @(posedge clk_i) disable iff (!rst_b_i)
        (trg_fall && !st_r.ctrl[TCR_B_EXEN] && !st_r.ctrl[TCR_B_EXF]
            && !ovf && !bus_i.wr) |=> !st_r.ctrl[TCR_B_EXF];
    endproperty
    a_trig_off: assert property (p_trig_off)
        else $error("trigger acted while disabled");

    property p_rx_baud;
        @(posedge clk_i) disable iff (!rst_b_i)
        (st_r.ctrl[TCR_B_RXCLK] && ovf) |=> rx_baud_o;
    endproperty
    a_rx_baud: assert property (p_rx_baud)
        else $error("receive baud tick missing");

    property p_tx_baud;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!st_r.ctrl[TCR_B_TXCLK] && pins_i.t1_ovf) |=> tx_baud_o;
    endproperty
    a_tx_baud: assert property (p_tx_baud)
        else $error("transmit baud tick missing");

    property p_counter;
        @(posedge clk_i) disable iff (!rst_b_i)
        (st_r.ctrl[TCR_B_RUN] && st_r.ctrl[TCR_B_CT] && !baud_mode
            && !cin_fall && !ext_edge && !bus_i.wr)
            |=> st_r.cnt == $past(st_r.cnt);
    endproperty
    a_counter: assert property (p_counter)
        else $error("counter moved without pin edge");

    c_cnt_in: cover property (@(posedge clk_i) cin_fall && step);
    c_ovf: cover property (@(posedge clk_i) ovf_up);
    c_dn: cover property (@(posedge clk_i) ovf_dn);
    c_cap: cover property (@(posedge clk_i) ext_edge);
    c_baud: cover property (@(posedge clk_i) baud_mode && ovf);
endmodule : tcr_timer

//--- design/tcr_pkg.sv
package tcr_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] TCR_ADDR_CTRL = 8'hC8;
    localparam logic [7:0] TCR_ADDR_MODE = 8'hC9;
    localparam logic [7:0] TCR_ADDR_RCL = 8'hCA;
    localparam logic [7:0] TCR_ADDR_RCH = 8'hCB;
    localparam logic [7:0] TCR_ADDR_CNTL = 8'hCC;
    localparam logic [7:0] TCR_ADDR_CNTH = 8'hCD;
    // control register field positions
    localparam int TCR_B_OVF = 7;
    localparam int TCR_B_EXF = 6;
    localparam int TCR_B_RXCLK = 5;
    localparam int TCR_B_TXCLK = 4;
    localparam int TCR_B_EXEN = 3;
    localparam int TCR_B_RUN = 2;
    localparam int TCR_B_CT = 1;
    localparam int TCR_B_CPRL = 0;
    // mode register field positions
    localparam int TCR_B_CRST = 3;
    localparam int TCR_B_OE = 1;
    localparam int TCR_B_DOWN_COUNT_ENABLE = 0;
    // writable mode bits; hardware-clear bits belong elsewhere
    localparam logic [7:0] TCR_MODE_MASK = 8'h0B;
    // reset values and the count maximum
    localparam logic [7:0] TCR_RST_BYTE = 8'h00;
    localparam logic [15:0] TCR_RST_WORD = 16'h0000;
    localparam logic [15:0] TCR_CNT_MAX = 16'hFFFF;
    // baud mode advances once per this many clocks
    localparam int TCR_BAUD_DIV = 2;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tcr_bus_t;

    // pin inputs and external tick sources
    typedef struct packed {
        logic trigger_pin;
        logic count_input_pin;
        logic tick;
        logic t1_ovf;
    } tcr_pins_t;
endpackage : tcr_pkg

//--- verification/tcr_pins_model.sv
`timescale 1ns/1ps
// far side: trigger pin, tick source and timer 1 overflow strobe
module tcr_pins_model
    import tcr_pkg::*;
#(
    parameter int T1_DIV = 8
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic trig_i,
    input wire logic tick_en_i,
    input wire logic cin_i,
    output tcr_pins_t pins_o
);
    int t1_cnt; // timer 1 prescale, free running
    // timer 1 overflows once every T1_DIV clocks
    always @(posedge clk_i) begin
        if (!rst_b_i || t1_cnt == T1_DIV - 1)
            t1_cnt <= 0;
        else
            t1_cnt <= t1_cnt + 1;
    end
    // count input level comes straight from the bench, idle high
    always_comb begin
        pins_o.trigger_pin = trig_i;
        pins_o.count_input_pin = cin_i;
        pins_o.tick = tick_en_i;
        pins_o.t1_ovf = (t1_cnt == T1_DIV - 1);
    end
endmodule : tcr_pins_model

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tcr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    tcr_bus_t bus_i = '0;
    tcr_pins_t pins;
    logic trig = 1'b1; // trigger level, idle high
    logic tick_en = 1'b0; // tick request to the far side
    logic cin = 1'b1; // count input level, idle high
    int mdl [int]; // shadow of what software last wrote
    logic [7:0] rdata_o;
    logic irq_o, rx_baud_o, tx_baud_o, clk_out_o;
    int errors = 0;
    int n_tests = 0;
    int nrx, ntx;
    logic [7:0] rv;
    always #2.5 clk_i = ~clk_i;
    tcr_pins_model u_tcr_pins_model (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .trig_i(trig), .tick_en_i(tick_en), .cin_i(cin), .pins_o(pins));
    tcr_timer u_tcr_timer (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
        .pins_i(pins), .rdata_o(rdata_o), .irq_o(irq_o),
        .rx_baud_o(rx_baud_o), .tx_baud_o(tx_baud_o),
        .clk_out_o(clk_out_o));
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i.addr <= a;
        bus_i.wdata <= d;
        bus_i.wr <= 1'b1;
        @(posedge clk_i);
        bus_i.wr <= 1'b0;
        // mode keeps only its writable bits
        if (a == TCR_ADDR_MODE)
            mdl[int'(a)] = int'(d & TCR_MODE_MASK);
        else
            mdl[int'(a)] = int'(d);
    endtask : wr
    // read; data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus_i.addr <= a;
        bus_i.rd <= 1'b1;
        @(posedge clk_i);
        bus_i.rd <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // n tick pulses from the far side
    task automatic ticks(input int n);
        @(posedge clk_i);
        tick_en <= 1'b1;
        repeat (n) @(posedge clk_i);
        tick_en <= 1'b0;
    endtask : ticks
    // count baud pulses over a 40 cycle window
    task automatic baud(input int erx, input int etx);
        nrx = 0;
        ntx = 0;
        repeat (8) @(posedge clk_i);
        repeat (40) begin
            @(posedge clk_i);
            #1 nrx += rx_baud_o;
            ntx += tx_baud_o;
        end
        chk(nrx, erx);
        chk(ntx, etx);
    endtask : baud
    task automatic stop_test;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    // watchdog well beyond the expected run
    initial begin
        #200000;
        errors++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h7FA1));
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // reset values, unmapped place reads zero
        for (int a = 8'hC7; a <= 8'hCE; a++) begin
            rd(a[7:0], rv);
            chk(rv, 16'h0000);
        end
        // random reload and count bytes read back against the shadow
        for (int i = 0; i < 4; i++) begin
            wr(TCR_ADDR_RCL + 8'(i), 8'($urandom));
        end
        for (int i = 0; i < 4; i++) begin
            rd(TCR_ADDR_RCL + 8'(i), rv);
            chk(rv, 16'(mdl[int'(TCR_ADDR_RCL) + i]));
        end
        wr(TCR_ADDR_MODE, 8'hFF);
        rd(TCR_ADDR_MODE, rv);
        chk(rv, 16'(mdl[int'(TCR_ADDR_MODE)]));
        wr(TCR_ADDR_MODE, 8'h00);
        // up count through overflow reloads 1234
        wr(TCR_ADDR_RCL, 8'h34);
        wr(TCR_ADDR_RCH, 8'h12);
        wr(TCR_ADDR_CNTL, 8'hFE);
        wr(TCR_ADDR_CNTH, 8'hFF);
        wr(TCR_ADDR_CTRL, 8'h04);
        ticks(3);
        rd(TCR_ADDR_CNTL, rv);
        chk(rv, 16'h35);
        rd(TCR_ADDR_CNTH, rv);
        chk(rv, 16'h12);
        rd(TCR_ADDR_CTRL, rv);
        chk(rv, 16'h84);
        chk(irq_o, 1'b1);
        // software clears and sets the flag
        wr(TCR_ADDR_CTRL, 8'h04);
        rd(TCR_ADDR_CTRL, rv);
        chk(rv, 16'h04);
        wr(TCR_ADDR_CTRL, 8'h80);
        ticks(4);
        rd(TCR_ADDR_CNTL, rv);
        chk(rv, 16'h35);
        rd(TCR_ADDR_CTRL, rv);
        chk(rv, 16'h80);
        // trigger ignored with external enable off
        wr(TCR_ADDR_CTRL, 8'h05);
        @(posedge clk_i) trig <= 1'b0;
        repeat (6) @(posedge clk_i);
        trig <= 1'b1;
        rd(TCR_ADDR_RCL, rv);
        chk(rv, 16'h34);
        // capture with capture-reset
        wr(TCR_ADDR_MODE, 8'h08);
        wr(TCR_ADDR_CNTL, 8'h00);
        wr(TCR_ADDR_CNTH, 8'h01);
        wr(TCR_ADDR_CTRL, 8'h0D);
        @(posedge clk_i) trig <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(TCR_ADDR_RCH, rv);
        chk(rv, 16'h01);
        rd(TCR_ADDR_CNTH, rv);
        chk(rv, 16'h00);
        rd(TCR_ADDR_CTRL, rv);
        chk(rv, 16'h4D);
        chk(irq_o, 1'b1);
        @(posedge clk_i) trig <= 1'b1;
        // baud mode: 4 clocks per overflow, flag stays clear
        wr(TCR_ADDR_CTRL, 8'h00);
        wr(TCR_ADDR_MODE, 8'h00);
        wr(TCR_ADDR_RCL, 8'hFE);
        wr(TCR_ADDR_RCH, 8'hFF);
        wr(TCR_ADDR_CNTL, 8'hFE);
        wr(TCR_ADDR_CNTH, 8'hFF);
        wr(TCR_ADDR_CTRL, 8'h34);
        baud(10, 10);
        rd(TCR_ADDR_CTRL, rv);
        chk(rv, 16'h34);
        wr(TCR_ADDR_CTRL, 8'h24);
        baud(10, 5);
        // down count to the reload match, then up through overflow
        wr(TCR_ADDR_CTRL, 8'h00);
        wr(TCR_ADDR_MODE, 8'h03);
        wr(TCR_ADDR_RCL, 8'h10);
        wr(TCR_ADDR_RCH, 8'h00);
        wr(TCR_ADDR_CNTL, 8'h12);
        wr(TCR_ADDR_CNTH, 8'h00);
        @(posedge clk_i) trig <= 1'b0;
        repeat (3) @(posedge clk_i);
        wr(TCR_ADDR_CTRL, 8'h04);
        ticks(3);
        rd(TCR_ADDR_CNTL, rv);
        chk(rv, 16'hFF);
        rd(TCR_ADDR_CTRL, rv);
        chk(rv, 16'hC4);
        chk(clk_out_o, 1'b1);
        @(posedge clk_i) trig <= 1'b1;
        repeat (3) @(posedge clk_i);
        ticks(2);
        rd(TCR_ADDR_CNTL, rv);
        chk(rv, 16'h11);
        chk(clk_out_o, 1'b0);
        // trigger edge reloads in plain auto-reload
        wr(TCR_ADDR_MODE, 8'h00);
        wr(TCR_ADDR_CTRL, 8'h0C);
        @(posedge clk_i) trig <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(TCR_ADDR_CNTL, rv);
        chk(rv, 16'h10);
        rd(TCR_ADDR_CTRL, rv);
        chk(rv, 16'h4C);
        chk(irq_o, 1'b1);
        @(posedge clk_i) trig <= 1'b1;
        // counter mode counts pin falls and ignores ticks
        wr(TCR_ADDR_CTRL, 8'h00);
        wr(TCR_ADDR_CNTL, 8'h00);
        wr(TCR_ADDR_CNTH, 8'h00);
        wr(TCR_ADDR_CTRL, 8'h06);
        repeat (3) begin
            @(posedge clk_i) cin <= 1'b0;
            repeat (2) @(posedge clk_i);
            cin <= 1'b1;
            repeat (2) @(posedge clk_i);
        end
        ticks(4);
        rd(TCR_ADDR_CNTL, rv);
        chk(rv, 16'h03);
        stop_test();
    end
endmodule : tb_top
